// ==== hdl/edge_latch.v ====
// Purpose: one-deep edge request latch with selectable polarity
// Assumes: line synchronous to ref_clk
// Notes: later edges while set are dropped, set wins over clear
`timescale 1ns/100ps
`default_nettype none
module edge_latch (
    input wire ref_clk,
    input wire rstn,
    input wire lineIn,
    input wire risingSel,
    input wire clearPulse,
    output reg pending
);
    reg lineDly;
    wire hit = risingSel ? (lineIn & ~lineDly) : (~lineIn & lineDly);
    // previous level and sticky latch
    always @(posedge ref_clk) begin
        if (!rstn) begin
            lineDly <= 1'b1;
            pending <= 1'b0;
        end else begin
            lineDly <= lineIn;
            if (hit)
                pending <= 1'b1; // [R11]
            else if (clearPulse)
                pending <= 1'b0; // [R11]
        end
    end
endmodule // edge_latch
`default_nettype wire

// ==== hdl/event_flags.v ====
// Purpose: per-event sticky flags that software polls
// Assumes: events are one-cycle pulses
// Notes: a write of one clears a flag; a new event wins
`timescale 1ns/100ps
`default_nettype none
module event_flags (
    input wire ref_clk,
    input wire rstn,
    input wire [7:0] evtIn,
    input wire [7:0] clrMask,
    input wire clrStb,
    output reg [7:0] flags
);
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_flag
            // set beats clear in the same cycle
            always @(posedge ref_clk) begin
                if (!rstn)
                    flags[i] <= 1'b0;
                else if (evtIn[i])
                    flags[i] <= 1'b1; // [R18]
                else if (clrStb && clrMask[i])
                    flags[i] <= 1'b0;
            end
        end
    endgenerate
endmodule // event_flags
`default_nettype wire

// ==== hdl/irq_unit_map.vh ====
// Purpose: constants for the prioritized interrupt unit
// Assumes: 12-bit program addresses, 8-bit data space
// Notes: option register is write-only
`ifndef IRQ_UNIT_MAP_VH
`define IRQ_UNIT_MAP_VH
`define IOPT_ADDR 8'hC8
`define IOPT_RESET 8'h00
`define IOPT_LES_BIT 6
`define IOPT_ESB_BIT 5
`define IOPT_GEN_BIT 4
`define VEC_SRC0 12'hFFC
`define VEC_SRC1 12'hFF6
`define VEC_SRC2 12'hFF4
`define VEC_SRC3 12'hFF2
`define VEC_SRC4 12'hFF0
`define EVT_STAT_ADDR 8'hE0
`define MODE_NORMAL 2'h0
`define MODE_IRQ 2'h1
`define MODE_NMI 2'h2
`endif

// ==== hdl/prioritized_interrupt_unit.v ====
// Purpose: fixed-priority interrupt unit beside an 8-bit core
// Assumes: core samples at instruction end, acks on routine entry
// Notes: nmi preempts any maskable routine, not its own; maskable ones never nest
//
// Strobed register access was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "irq_unit_map.vh"
// Summary of operation
// [R1] nmi preempts any routine; maskable sources never preempt each other (here nmi is held off during an nmi routine)
// [R2] pending maskable requests served in fixed order, source 1 first
// [R3] accepted request loads program counter with that source's vector
// [R4] vectors FFC, FF6, FF4, FF2, FF0 for sources 0 to 4
// [R5] global enable set allows all; cleared blocks maskable, nmi stays
// [R6] with enable low nmi still served but gives no wake-up
// [R7] nmi held in flip-flop cleared when its routine begins
// [R8] level/edge bit makes source 1 level when set, falling edge else
// [R9] source 2 always edge; polarity bit set rising, cleared falling
// [R10] sources 3 and 4 are level sensitive only
// [R11] edge latch set by edge, cleared at entry, holds only one
// [R12] level requester holds line low when sampled at instruction end
// [R13] lines tested at instruction end; routine replaces next instruction
// [R14] entry swaps flag set, pushes pc, inhibits maskable, loads vector
// [R15] three flag sets for normal, interrupt and nmi, switched in hardware
// [R16] return restores previous flag set and pops saved program counter
// [R17] option register at C8 write-only, reset zero, unused bits ignored
// [R18] each or-combined event keeps its own pollable flag
// [R19] spi to 1, ports to 2, timers and oscillator to 3, converter to 4
// [R20] wait or stop refused while enabled request pending
// [R21] single request strobe with source index, ack marks entry
module prioritized_interrupt_unit (
    input wire ref_clk,
    input wire rstn,
    // register port
    input wire [7:0] regAddr,
    input wire [7:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [7:0] regRdata,
    // request lines; nmi and source 1 active low, port line polarity selectable
    input wire nmiLineN,
    input wire extLine1N,
    input wire portLine,
    // peripheral events
    input wire spiDoneEvt,
    input wire timerZeroEvt,
    input wire slowOscEvt,
    input wire reloadOvfEvt,
    input wire reloadCmpEvt,
    input wire reloadEdgeEvt,
    input wire convDoneEvt,
    // peripheral level requests (already masked)
    input wire spiReq,
    input wire timerReq,
    input wire slowOscReq,
    input wire reloadReq,
    input wire convReq,
    // core side
    input wire instrEnd,
    input wire irqAck,
    input wire retiExec,
    input wire sleepReq,
    input wire [1:0] flagsIn,
    input wire flagsWr,
    input wire [11:0] pcIn,
    output wire irqReq,
    output reg [2:0] irqSrc,
    output reg [11:0] irqVector,
    output wire [1:0] flagsOut,
    output reg [11:0] pcOut,
    output reg [1:0] modeOut,
    output wire sleepAllow,
    output wire wakeUp
);
    reg [7:0] interrupt_option_reg;
    reg [1:0] modeReg;
    reg [1:0] prevModeReg;
    reg nmiPending;
    reg [1:0] flagSet [0:2];
    reg [11:0] stackPc [0:1];
    reg stackPtr;
    reg nmiLineDly;
    reg [2:0] srcNext;
    reg [11:0] vecNext;
    reg reqNext;
    wire globalIrqEnable = interrupt_option_reg[`IOPT_GEN_BIT];
    wire levelEdgeSelect = interrupt_option_reg[`IOPT_LES_BIT];
    wire edgePolaritySelect = interrupt_option_reg[`IOPT_ESB_BIT];
    wire src1EdgePend;
    wire src2EdgePend;
    wire [7:0] evtFlags;
    wire optWrite = regWr && (regAddr == `IOPT_ADDR);
    wire flagClr = regWr && (regAddr == `EVT_STAT_ADDR);
    wire ackNmi = irqAck && (irqSrc == 3'd0);
    wire ackSrc1 = irqAck && (irqSrc == 3'd1);
    wire ackSrc2 = irqAck && (irqSrc == 3'd2);

    // option register, whole byte writes only, no readback
    always @(posedge ref_clk) begin
        if (!rstn)
            interrupt_option_reg <= `IOPT_RESET; // [R17]
        else if (optWrite)
            interrupt_option_reg <= {1'b0, regWdata[6:4], 4'h0}; // [R17]
    end

    // read path: option register is write-only and reads zero
    always @(posedge ref_clk) begin
        if (!rstn)
            regRdata <= 8'h00;
        else if (regRd && regAddr == `EVT_STAT_ADDR)
            regRdata <= evtFlags; // [R18]
        else
            regRdata <= 8'h00; // [R17]
    end

    // nmi falling edge latch; set wins over the ack clear
    always @(posedge ref_clk) begin
        if (!rstn) begin
            nmiLineDly <= 1'b1;
            nmiPending <= 1'b0;
        end else begin
            nmiLineDly <= nmiLineN;
            if (nmiLineDly && !nmiLineN)
                nmiPending <= 1'b1; // [R7]
            else if (ackNmi)
                nmiPending <= 1'b0; // [R7]
        end
    end

    // source 1 edge path, falling edge only
    edge_latch u_src1 (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .lineIn(extLine1N),
        .risingSel(1'b0),
        .clearPulse(ackSrc1),
        .pending(src1EdgePend)
    );

    // source 2 always edge, polarity selectable
    edge_latch u_src2 (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .lineIn(portLine),
        .risingSel(edgePolaritySelect), // [R9]
        .clearPulse(ackSrc2),
        .pending(src2EdgePend)
    );

    // per-event flags for polling inside shared routines
    event_flags u_flags (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .evtIn({1'b0, spiDoneEvt, convDoneEvt, reloadEdgeEvt, reloadCmpEvt, reloadOvfEvt, slowOscEvt, timerZeroEvt}),
        .clrMask(regWdata),
        .clrStb(flagClr),
        .flags(evtFlags)
    );

    // source request levels after routing
    wire src1Pend = (levelEdgeSelect ? !extLine1N : src1EdgePend) | spiReq; // [R8] [R19]
    wire src2Pend = src2EdgePend; // [R19]
    wire src3Pend = timerReq | slowOscReq | reloadReq; // [R10] [R19]
    wire src4Pend = convReq; // [R10] [R19]
    wire anyMaskable = src1Pend | src2Pend | src3Pend | src4Pend;
    // maskable lines inhibited outside normal mode
    wire maskOk = globalIrqEnable && (modeReg == `MODE_NORMAL); // [R5] [R1] [R14]
    wire nmiOk = nmiPending && (modeReg != `MODE_NMI); // [R1] [R5]

    // fixed priority pick, nmi first then 1 down to 4
    always @* begin
        reqNext = 1'b1;
        srcNext = 3'd0;
        vecNext = `VEC_SRC0; // [R4]
        if (nmiOk) begin
            srcNext = 3'd0;
            vecNext = `VEC_SRC0;
        end else if (maskOk && src1Pend) begin // [R2]
            srcNext = 3'd1;
            vecNext = `VEC_SRC1;
        end else if (maskOk && src2Pend) begin
            srcNext = 3'd2;
            vecNext = `VEC_SRC2;
        end else if (maskOk && src3Pend) begin
            srcNext = 3'd3;
            vecNext = `VEC_SRC3;
        end else if (maskOk && src4Pend) begin
            srcNext = 3'd4;
            vecNext = `VEC_SRC4;
        end else begin
            reqNext = 1'b0;
        end
    end

    // request held valid from instruction end until ack
    reg reqHeld;
    always @(posedge ref_clk) begin
        if (!rstn) begin
            reqHeld <= 1'b0;
            irqSrc <= 3'd0;
            irqVector <= 12'h000;
        end else if (irqAck) begin
            reqHeld <= 1'b0;
        end else if (instrEnd && !reqHeld && reqNext) begin
            reqHeld <= 1'b1; // [R13]
            irqSrc <= srcNext; // [R21]
            irqVector <= vecNext; // [R3]
        end
    end
    assign irqReq = reqHeld; // [R21]

    // mode tracking, one saved level since maskable never nests
    always @(posedge ref_clk) begin
        if (!rstn) begin
            modeReg <= `MODE_NORMAL;
            prevModeReg <= `MODE_NORMAL;
            stackPtr <= 1'b0;
            stackPc[0] <= 12'h000;
            stackPc[1] <= 12'h000;
            pcOut <= 12'h000;
        end else if (irqAck) begin
            prevModeReg <= modeReg; // [R14]
            modeReg <= (irqSrc == 3'd0) ? `MODE_NMI : `MODE_IRQ; // [R15]
            stackPc[stackPtr] <= pcIn; // [R14]
            stackPtr <= ~stackPtr;
            pcOut <= irqVector; // [R3] [R14]
        end else if (retiExec && modeReg != `MODE_NORMAL) begin
            // nmi over irq returns to irq, else to normal
            modeReg <= (modeReg == `MODE_NMI) ? prevModeReg : `MODE_NORMAL; // [R16]
            prevModeReg <= `MODE_NORMAL;
            stackPtr <= ~stackPtr;
            pcOut <= stackPc[~stackPtr]; // [R16]
        end
    end

    // three carry/zero pairs, the live one follows the mode
    always @(posedge ref_clk) begin
        if (!rstn) begin
            flagSet[0] <= 2'b00;
            flagSet[1] <= 2'b00;
            flagSet[2] <= 2'b00;
        end else if (flagsWr) begin
            flagSet[modeReg] <= flagsIn; // [R15]
        end
    end
    assign flagsOut = flagSet[modeReg]; // [R14] [R15]

    // mode output registered for the core
    always @(posedge ref_clk) begin
        if (!rstn)
            modeOut <= `MODE_NORMAL;
        else
            modeOut <= modeReg;
    end

    // sleep is refused while anything enabled waits
    wire enabledPending = nmiPending | (globalIrqEnable & anyMaskable);
    assign sleepAllow = sleepReq && !enabledPending; // [R20]
    // wake-up only with global enable; with it low nmi cannot wake
    assign wakeUp = globalIrqEnable && enabledPending; // [R6]
endmodule // prioritized_interrupt_unit
`default_nettype wire

// ==== tb/irq_core_model.sv ====
// Purpose: behavioural core facing the interrupt unit
// Assumes: four-cycle instructions
// Notes: ack latency set per entry by the bench
`timescale 1ns/100ps
`default_nettype none
module irq_core_model (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic irqReq,
    input wire logic [3:0] ackDelay,
    output logic instrEnd,
    output logic irqAck
);
    logic [1:0] cyc;
    logic [3:0] wt;
    // no instruction ends while an entry waits, so no double sample
    always @(posedge ref_clk) begin
        if (!rstn) begin
            cyc <= 2'h0;
            wt <= 4'h0;
            instrEnd <= 1'b0;
            irqAck <= 1'b0;
        end else begin
            cyc <= cyc + 2'h1;
            instrEnd <= (cyc == 2'h3) && !irqReq;
            wt <= (irqReq && !irqAck) ? wt + 4'h1 : 4'h0;
            irqAck <= irqReq && !irqAck && (wt >= ackDelay);
        end
    end
endmodule // irq_core_model
`default_nettype wire

// ==== tb/irq_unit_monitor.sv ====
// Purpose: port checks on the interrupt unit
// Assumes: core strobes are one-cycle pulses
// Notes: mode updates get one cycle of slack
`timescale 1ns/100ps
`default_nettype none
`include "irq_unit_map.vh"
module irq_unit_monitor (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic instrEnd,
    input wire logic irqAck,
    input wire logic retiExec,
    input wire logic irqReq,
    input wire logic [2:0] irqSrc,
    input wire logic [11:0] irqVector,
    input wire logic [11:0] pcOut,
    input wire logic [1:0] modeOut,
    input wire logic sleepAllow
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // request stands with a steady source until the core takes it
    a_req_holds: assert property (irqReq && !irqAck |=> irqReq && $stable(irqSrc))
        else $error("request changed before acknowledge");
    a_ack_drops: assert property (irqReq && irqAck |=> !irqReq)
        else $error("request still up after acknowledge");
    a_rise_cause: assert property ($rose(irqReq) |-> $past(instrEnd))
        else $error("request raised outside an instruction end");
    a_vec_map: assert property (irqReq |-> irqVector == (irqSrc == 3'h0 ? `VEC_SRC0 : irqSrc == 3'h1 ? `VEC_SRC1 :
        irqSrc == 3'h2 ? `VEC_SRC2 : irqSrc == 3'h3 ? `VEC_SRC3 : `VEC_SRC4))
        else $error("vector does not match source");
    a_pc_vector: assert property (irqReq && irqAck |=> pcOut == $past(irqVector))
        else $error("program counter not loaded with vector");
    a_no_nest: assert property ($rose(irqReq) && irqSrc != 3'h0 |-> modeOut == `MODE_NORMAL)
        else $error("maskable request raised inside a routine");
    a_nmi_mode: assert property (irqReq && irqAck && irqSrc == 3'h0 |-> ##[1:2] modeOut == `MODE_NMI)
        else $error("nmi entry did not switch flag set");
    a_return_from_interrupt_instr_back: assert property (retiExec && modeOut == `MODE_IRQ |-> ##[1:2] modeOut == `MODE_NORMAL)
        else $error("return did not restore normal set");
    a_sleep_block: assert property (irqReq |-> !sleepAllow)
        else $error("sleep allowed with request pending");
endmodule // irq_unit_monitor
bind prioritized_interrupt_unit irq_unit_monitor i_irq_unit_monitor (.*);
`default_nettype wire

// ==== tb/prioritized_interrupt_unit_tb_top.sv ====
// Purpose: self-checking bench for the interrupt unit
// Assumes: core model acks each entry
// Notes: expected results queued, watcher pops
`timescale 1ns/100ps
`default_nettype none
`include "irq_unit_map.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; $display("ERROR %0t got %h want %h", $time, a, b); end end
module prioritized_interrupt_unit_tb_top;
    logic ref_clk = 0, rstn = 0, regWr = 0, regRd = 0, nmiLineN = 1, extLine1N = 1, portLine = 1;
    logic retiExec = 0, sleepReq = 0, flagsWr = 0, instrEnd, irqAck, irqReq, sleepAllow, wakeUp, rdD = 0, popD = 0;
    logic [7:0] regAddr = 0, regWdata = 0, regRdata;
    logic [6:0] evts = 0;
    logic [4:0] lv = 0;
    logic [3:0] ackDelay = 0;
    logic [1:0] flagsIn = 0, flagsOut, modeOut;
    logic [11:0] pcIn = 0, irqVector, pcOut, pv;
    logic [2:0] irqSrc;
    logic genOn = 0;
    logic [14:0] q[$], e;
    logic [11:0] stk[$];
    int error_cnt = 0, checked = 0, cycles = 0, n, i, k;
    integer seed = 1;
    wire timerZeroEvt = evts[0], slowOscEvt = evts[1], reloadOvfEvt = evts[2], reloadCmpEvt = evts[3];
    wire reloadEdgeEvt = evts[4], convDoneEvt = evts[5], spiDoneEvt = evts[6];
    wire spiReq = lv[0], timerReq = lv[1], slowOscReq = lv[2], reloadReq = lv[3], convReq = lv[4];
    prioritized_interrupt_unit i_prioritized_interrupt_unit (.*);
    irq_core_model i_irq_core_model (.ref_clk(ref_clk), .rstn(rstn), .irqReq(irqReq), .ackDelay(ackDelay),
        .instrEnd(instrEnd), .irqAck(irqAck));
    always #20 ref_clk = ~ref_clk;
    function automatic logic [11:0] vec(input logic [2:0] s);
        return (s == 3'h0) ? 12'hFFC : 12'hFF8 - {8'h00, s, 1'b0};
    endfunction
    task tally_and_finish;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task wr(input logic [7:0] a, d);
        @(posedge ref_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, x);
        q.push_back({7'h00, x});
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask
    // expect one entry, then drop that source's level once it is taken
    task serve(input logic [2:0] s);
        q.push_back({s, vec(s)});
        ackDelay <= 4'($random(seed));
        n = 0;
        while (!(irqAck && irqReq) && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK(irqAck && irqReq, 1'b1)
        `CHK(wakeUp, genOn)
        `CHK(sleepAllow, 1'b0)
        @(posedge ref_clk);
        if (s == 3'h1) lv[0] <= 1'b0;
        if (s == 3'h1) extLine1N <= 1'b1;
        if (s == 3'h3) lv[3:1] <= 3'h0;
        if (s == 3'h4) lv[4] <= 1'b0;
    endtask
    task return_from_interrupt_instr;
        @(posedge ref_clk);
        retiExec <= 1'b1;
        @(posedge ref_clk);
        retiExec <= 1'b0;
    endtask
    // write the live flag pair and read it back
    task fw(input logic [1:0] v);
        @(posedge ref_clk);
        flagsIn <= v;
        flagsWr <= 1'b1;
        @(posedge ref_clk);
        flagsWr <= 1'b0;
        @(negedge ref_clk);
        `CHK(flagsOut, v)
    endtask
    // low pulse on one pin: falling edge, then rising edge
    task pul(input logic [2:0] w);
        @(posedge ref_clk);
        if (w == 3'h0) nmiLineN <= 1'b0;
        if (w == 3'h1) extLine1N <= 1'b0;
        if (w == 3'h2) portLine <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nmiLineN <= 1'b1;
        extLine1N <= 1'b1;
        portLine <= 1'b1;
        @(posedge ref_clk);
    endtask
    // watcher: oldest note against each result; pc stack mirrors entries
    always @(posedge ref_clk) begin
        pcIn <= 12'($random(seed));
        if (rdD) begin
            e = q.size() ? q.pop_front() : 15'h7FFF;
            `CHK({7'h00, regRdata}, e)
        end
        if (irqAck && irqReq) begin
            e = q.size() ? q.pop_front() : 15'h7FFF;
            `CHK({irqSrc, irqVector}, e)
            stk.push_back(pcIn);
        end
        if (popD) begin
            pv = stk.size() ? stk.pop_back() : 12'h000;
            `CHK(pcOut, pv)
        end
        rdD <= regRd;
        popD <= retiExec;
        cycles++;
        if (cycles > 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        sleepReq <= 1'b1;
        rd(`IOPT_ADDR, 8'h00);
        rd(8'h55, 8'h00);
        for (i = 0; i < 7; i++) begin
            @(posedge ref_clk);
            evts <= 7'(1 << i);
            @(posedge ref_clk);
            evts <= 7'h00;
            rd(`EVT_STAT_ADDR, 8'(1 << i));
            wr(`EVT_STAT_ADDR, 8'h7F);
        end
        lv[4] <= 1'b1;
        repeat (40) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK(sleepAllow, 1'b1)
        `CHK(wakeUp, 1'b0)
        fw(2'b01);
        pul(3'h0);
        serve(3'h0);
        @(negedge ref_clk);
        `CHK(flagsOut, 2'b00)
        fw(2'b10);
        return_from_interrupt_instr;
        @(negedge ref_clk);
        `CHK(flagsOut, 2'b01)
        wr(`IOPT_ADDR, 8'h10);
        genOn = 1'b1;
        serve(3'h4);
        @(negedge ref_clk);
        `CHK(flagsOut, 2'b00)
        fw(2'b11);
        // pile up edges and a level while maskables are inhibited
        pul(3'h1);
        pul(3'h2);
        pul(3'h2);
        k = 1 + {$random(seed)} % 3;
        lv[k] <= 1'b1;
        return_from_interrupt_instr;
        serve(3'h1);
        return_from_interrupt_instr;
        serve(3'h2);
        return_from_interrupt_instr;
        serve(3'h3);
        pul(3'h0);
        serve(3'h0);
        @(negedge ref_clk);
        `CHK(flagsOut, 2'b10)
        return_from_interrupt_instr;
        @(negedge ref_clk);
        `CHK(flagsOut, 2'b11)
        return_from_interrupt_instr;
        @(negedge ref_clk);
        `CHK(flagsOut, 2'b01)
        repeat (40) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK(sleepAllow, 1'b1)
        wr(`IOPT_ADDR, 8'h70);
        extLine1N <= 1'b0;
        serve(3'h1);
        return_from_interrupt_instr;
        pul(3'h2);
        serve(3'h2);
        return_from_interrupt_instr;
        lv[0] <= 1'b1;
        serve(3'h1);
        return_from_interrupt_instr;
        repeat (20) @(posedge ref_clk);
        `CHK(q.size(), 0)
        tally_and_finish();
    end
endmodule // prioritized_interrupt_unit_tb_top
`default_nettype wire
